// ### dcio_defines.vh
`ifndef DCIO_DEFINES_VH
`define DCIO_DEFINES_VH
// input function modes
`define DCIO_MODE_DEFAULT   4'h0
`define DCIO_MODE_REV_PRE   4'h2
`define DCIO_MODE_UP_FF1    4'h4
`define DCIO_MODE_UP_EXT    4'h5
`define DCIO_MODE_REV_UPDN  4'h6
`define DCIO_MODE_PRE_EXT   4'h7
// analog ranges
`define DCIO_RANGE_0_10V    2'h0
`define DCIO_RANGE_0_20MA   2'h1
`define DCIO_RANGE_4_20_FLT 2'h2
`define DCIO_RANGE_4_20_FF1 2'h3
// stop mode
`define DCIO_STOP_COAST     1'b0
// fault code limits
`define DCIO_FAULT_MAX      4'hd
// timing
`define DCIO_CLK_HZ         25000000
`define DCIO_TICK_HZ        8
`define DCIO_TICK_DIV       (`DCIO_CLK_HZ / `DCIO_TICK_HZ)
`define DCIO_RUN_CYCLE_TICKS 16
`define DCIO_PAUSE_TICKS    16
`endif

// ### dcio_tick_gen.v
`timescale 1ns/1ns
`include "dcio_defines.vh"
module dcio_tick_gen #(
  parameter DIV = `DCIO_TICK_DIV
)(
  // clock and reset
  input  wire sys_clk_i,
  input  wire nrst_i,
  // tick out
  output reg  tick_o
);
  reg [23:0] cnt;

  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt    <= 24'h000000;
      tick_o <= 1'b0;
    end
    else if (cnt == DIV - 1)
    begin
      cnt    <= 24'h000000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt    <= cnt + 24'h000001;
      tick_o <= 1'b0;
    end
  end
endmodule // dcio_tick_gen

// ### dcio_control.v
`timescale 1ns/1ns
`include "dcio_defines.vh"
module dcio_control #(
  parameter ADC_W    = 12,
  parameter TICK_DIV = `DCIO_TICK_DIV
)(
  // clock and reset
  input  wire             sys_clk_i,
  input  wire             nrst_i,
  // terminal pins
  input  wire             digital_input_one_i,
  input  wire             digital_input_two_i,
  input  wire             digital_input_three_i,
  input  wire             digital_input_four_i,
  // analog front end
  input  wire [ADC_W-1:0] analog_reference_input_i,
  input  wire             loop_below_3ma_i,
  // configuration
  input  wire [3:0]       input_mode_i,
  input  wire [1:0]       analog_range_i,
  input  wire [7:0]       analog_scale_i,
  input  wire             analog_invert_i,
  input  wire             stop_mode_i,
  // drive state
  input  wire             mains_present_i,
  input  wire             internal_power_supply_ok_i,
  input  wire             comm_fault_i,
  input  wire [3:0]       fault_code_i,
  input  wire             output_freq_zero_i,
  input  wire             dc_brake_i,
  // decoded functions
  output reg              forward_enable_o,
  output reg              reverse_enable_o,
  output reg              fixed_frequency_one_o,
  output reg  [1:0]       preset_frequency_select_o,
  output reg              speed_up_o,
  output reg              speed_down_o,
  output reg              external_fault_input_o,
  output reg              analog_mode_o,
  output reg  [ADC_W-1:0] analog_reference_o,
  output reg              loop_open_fault_o,
  output reg              loop_open_ff1_o,
  // relay and LEDs
  output reg              run_relay_o,
  output reg              run_led_green_o,
  output reg              status_led_red_o,
  output reg              code_led_red_o,
  output reg              code_led_yellow_o
);
  // display states
  localparam D_OFF   = 3'h0;
  localparam D_IDLE  = 3'h1;
  localparam D_RUN   = 3'h2;
  localparam D_UV    = 3'h3;
  localparam D_FAULT = 3'h4;
  localparam D_COMM  = 3'h5;
  localparam D_CODE  = 3'h6;
  localparam D_BRAKE = 3'h7;

  wire [3:0]  s2;
  reg  [3:0]  shown_code;
  reg         loop_s1;
  reg         loop_s2;
  wire        tick;
  reg  [2:0]  disp;
  reg  [2:0]  next_disp;
  reg  [4:0]  tcnt;
  reg  [4:0]  pulses;
  reg         in_pause;
  reg         fault_any;
  reg         enable;
  reg         relay_hold;
  reg  [ADC_W-1:0] a_inv;
  reg  [ADC_W+7:0] a_mul;
  reg         digital_mode;
  reg         ext_flt;

  dcio_tick_gen #(
    .DIV (TICK_DIV)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .tick_o    (tick)
  );

  // two-stage synchronisers, identical per input
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_sync
      wire pin;
      reg  sa;
      reg  sb;
      assign pin = (g == 0) ? digital_input_one_i :
                   (g == 1) ? digital_input_two_i :
                   (g == 2) ? digital_input_three_i : digital_input_four_i;
      assign s2[g] = sb;
      always @(posedge sys_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          sa <= 1'b0;
          sb <= 1'b0;
        end
        else
        begin
          sa <= pin;
          sb <= sa;
        end
      end
    end
  endgenerate

  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      loop_s1 <= 1'b0;
      loop_s2 <= 1'b0;
    end
    else
    begin
      loop_s1 <= loop_below_3ma_i;
      loop_s2 <= loop_s1;
    end
  end

  // input function decode
  always @*
  begin
    digital_mode = (input_mode_i == `DCIO_MODE_REV_PRE) ||
                   (input_mode_i == `DCIO_MODE_UP_FF1) ||
                   (input_mode_i == `DCIO_MODE_UP_EXT) ||
                   (input_mode_i == `DCIO_MODE_REV_UPDN) ||
                   (input_mode_i == `DCIO_MODE_PRE_EXT);
    ext_flt = ((input_mode_i == `DCIO_MODE_UP_EXT) ||
               (input_mode_i == `DCIO_MODE_PRE_EXT)) && s2[2];
    fault_any = (fault_code_i != 4'h0) || ext_flt || comm_fault_i ||
                (loop_s2 && (analog_range_i == `DCIO_RANGE_4_20_FLT));
    // term2 enables wherever it decodes as reverse, unlisted modes included
    enable = s2[0] || (!(input_mode_i == `DCIO_MODE_UP_FF1 ||
                         input_mode_i == `DCIO_MODE_UP_EXT ||
                         input_mode_i == `DCIO_MODE_PRE_EXT) && s2[1]);
    a_inv = analog_invert_i ? ~analog_reference_input_i
                            : analog_reference_input_i;
    a_mul = a_inv * analog_scale_i;
  end

  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      forward_enable_o          <= 1'b0;
      reverse_enable_o          <= 1'b0;
      fixed_frequency_one_o     <= 1'b0;
      preset_frequency_select_o <= 2'h0;
      speed_up_o                <= 1'b0;
      speed_down_o              <= 1'b0;
      external_fault_input_o    <= 1'b0;
      analog_mode_o             <= 1'b1;
      analog_reference_o        <= {ADC_W{1'b0}};
      loop_open_fault_o         <= 1'b0;
      loop_open_ff1_o           <= 1'b0;
    end
    else
    begin
      forward_enable_o          <= s2[0];
      reverse_enable_o          <= 1'b0;
      fixed_frequency_one_o     <= 1'b0;
      preset_frequency_select_o <= 2'h0;
      speed_up_o                <= 1'b0;
      speed_down_o              <= 1'b0;
      external_fault_input_o    <= ext_flt;
      analog_mode_o             <= ~digital_mode;
      case (input_mode_i)
        `DCIO_MODE_REV_PRE:
        begin
          reverse_enable_o          <= s2[1];
          preset_frequency_select_o <= {s2[3], s2[2]};
        end
        `DCIO_MODE_UP_FF1:
        begin
          speed_up_o            <= s2[1];
          fixed_frequency_one_o <= s2[2];
          speed_down_o          <= s2[3];
        end
        `DCIO_MODE_UP_EXT:
        begin
          speed_up_o   <= s2[1];
          speed_down_o <= s2[3];
        end
        `DCIO_MODE_REV_UPDN:
        begin
          reverse_enable_o <= s2[1];
          speed_up_o       <= s2[2];
          speed_down_o     <= s2[3];
        end
        `DCIO_MODE_PRE_EXT:
          preset_frequency_select_o <= {s2[3], s2[1]};
        default:
        begin
          reverse_enable_o      <= s2[1];
          fixed_frequency_one_o <= s2[2];
        end
      endcase
      // analog path, current ranges treated alike after conversion
      analog_reference_o <= digital_mode ? {ADC_W{1'b0}}
                                         : a_mul[ADC_W+6:7];
      loop_open_fault_o <= ~digital_mode && loop_s2 &&
                           (analog_range_i == `DCIO_RANGE_4_20_FLT);
      loop_open_ff1_o   <= ~digital_mode && loop_s2 &&
                           (analog_range_i == `DCIO_RANGE_4_20_FF1);
    end
  end

  // run relay
  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      run_relay_o <= 1'b0;
      relay_hold  <= 1'b0;
    end
    else if (fault_any)
    begin
      run_relay_o <= 1'b0;
      relay_hold  <= 1'b0;
    end
    else if (enable)
    begin
      run_relay_o <= 1'b1;
      relay_hold  <= 1'b1;
    end
    else if (stop_mode_i == `DCIO_STOP_COAST)
    begin
      run_relay_o <= 1'b0;
      relay_hold  <= 1'b0;
    end
    else if (relay_hold && output_freq_zero_i)
    begin
      run_relay_o <= 1'b0;
      relay_hold  <= 1'b0;
    end
  end

  // LED display state, supply loss first, then faults
  always @*
  begin
    if (!internal_power_supply_ok_i || !mains_present_i)
      next_disp = D_UV;
    else if (comm_fault_i)
      next_disp = D_COMM;
    else if (fault_code_i != 4'h0 && fault_code_i <= `DCIO_FAULT_MAX)
      next_disp = D_CODE;
    else if (fault_any)
      next_disp = D_FAULT;
    else if (dc_brake_i)
      next_disp = D_BRAKE;
    else if (enable)
      next_disp = D_RUN;
    else
      next_disp = D_IDLE;
  end

  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      disp       <= D_OFF;
      shown_code <= 4'h0;
      tcnt       <= 5'h00;
      pulses     <= 5'h00;
      in_pause   <= 1'b0;
    end
    else if (next_disp != disp || fault_code_i != shown_code)
    begin
      // a new code restarts the train so the count never overruns it
      disp       <= next_disp;
      shown_code <= fault_code_i;
      tcnt     <= 5'h00;
      pulses   <= 5'h00;
      in_pause <= 1'b0;
    end
    else if (tick)
    begin
      if (disp == D_CODE)
      begin
        if (in_pause)
        begin
          if (tcnt == `DCIO_PAUSE_TICKS - 1)
          begin
            tcnt     <= 5'h00;
            in_pause <= 1'b0;
          end
          else
            tcnt <= tcnt + 5'h01;
        end
        else if (tcnt == 5'h03)
        begin
          tcnt <= 5'h00;
          if (pulses + 5'h01 == {1'b0, fault_code_i})
          begin
            pulses   <= 5'h00;
            in_pause <= 1'b1;
          end
          else
            pulses <= pulses + 5'h01;
        end
        else
          tcnt <= tcnt + 5'h01;
      end
      else if (tcnt == `DCIO_RUN_CYCLE_TICKS - 1)
        tcnt <= 5'h00;
      else
        tcnt <= tcnt + 5'h01;
    end
  end

  // LED drive, one tick is 125 ms
  always @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      run_led_green_o   <= 1'b0;
      status_led_red_o  <= 1'b0;
      code_led_red_o    <= 1'b0;
      code_led_yellow_o <= 1'b0;
    end
    else
    begin
      run_led_green_o   <= 1'b0;
      status_led_red_o  <= 1'b0;
      code_led_red_o    <= 1'b0;
      code_led_yellow_o <= 1'b0;
      case (disp)
        D_IDLE:
          run_led_green_o <= (tcnt == 5'h00);
        D_RUN:
          run_led_green_o <= 1'b1;
        D_UV:
        begin
          status_led_red_o <= tcnt[1] == 1'b0;
          code_led_red_o   <= tcnt[1] == 1'b0;
        end
        D_COMM:
        begin
          status_led_red_o <= 1'b1;
          code_led_red_o   <= 1'b1;
        end
        D_FAULT:
        begin
          status_led_red_o <= 1'b1;
          code_led_red_o   <= 1'b1;
        end
        D_CODE:
        begin
          status_led_red_o <= 1'b1;
          code_led_red_o   <= ~in_pause && (tcnt[1] == 1'b0);
        end
        D_BRAKE:
          code_led_yellow_o <= 1'b1;
        default:
          run_led_green_o <= 1'b0;
      endcase
    end
  end
endmodule // dcio_control

// ### dcio_switches.sv
`timescale 1ns/1ns
module dcio_switches (
  // contacts closed by the operator, bit 0 is terminal one
  input  wire [3:0] closed_i,
  // terminal levels, an open contact is pulled down to low
  output wire [3:0] term_o
);
  assign term_o = closed_i;
endmodule // dcio_switches

// ### dcio_control_monitor.sv
`timescale 1ns/1ns
module dcio_control_monitor #(
  parameter ADC_W    = 12,
  parameter TICK_DIV = 4
)(
  // clock and reset
  input wire       sys_clk_i,
  input wire       nrst_i,
  // configuration and drive state
  input wire [3:0] input_mode_i,
  input wire       stop_mode_i,
  input wire       mains_present_i,
  input wire       internal_power_supply_ok_i,
  input wire       comm_fault_i,
  input wire [3:0] fault_code_i,
  input wire       output_freq_zero_i,
  input wire       dc_brake_i,
  // watched outputs
  input wire       forward_enable_o,
  input wire       reverse_enable_o,
  input wire       analog_mode_o,
  input wire       run_relay_o,
  input wire       run_led_green_o,
  input wire       status_led_red_o,
  input wire       code_led_red_o,
  input wire       code_led_yellow_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  wire enabled = forward_enable_o | reverse_enable_o;
  wire sup_ok  = mains_present_i & internal_power_supply_ok_i;
  sequence s_comm_held;
    (comm_fault_i && sup_ok)[*3];
  endsequence
  sequence s_coded_held;
    (fault_code_i != 4'h0 && sup_ok && !comm_fault_i)[*3];
  endsequence
  sequence s_brake_held;
    (dc_brake_i && fault_code_i == 4'h0 && sup_ok && !comm_fault_i)[*3];
  endsequence
  sequence s_run_held;
    (forward_enable_o && !dc_brake_i && fault_code_i == 4'h0 && sup_ok && !comm_fault_i)[*3];
  endsequence
  a_fault_opens_relay: assert property (fault_code_i != 4'h0 |=> !run_relay_o)
    else $error("relay closed after a fault code");
  a_relay_needs_enable: assert property ($rose(run_relay_o) |-> enabled && $past(fault_code_i) == 4'h0)
    else $error("relay closed without enable or with fault");
  a_coast_opens_relay: assert property (!enabled && !stop_mode_i |-> !run_relay_o)
    else $error("relay closed under coast stop without enable");
  a_ramp_holds_relay: assert property ($fell(enabled) && $past(run_relay_o) && stop_mode_i
    && !$past(output_freq_zero_i) && $past(fault_code_i) == 4'h0 |-> run_relay_o)
    else $error("relay opened before ramp reached zero");
  a_ramp_opens_relay: assert property (stop_mode_i && output_freq_zero_i && !enabled
    |-> ##[0:2] !run_relay_o)
    else $error("relay still closed at zero frequency");
  a_comm_leds_steady: assert property (s_comm_held |-> status_led_red_o && code_led_red_o
    && !run_led_green_o)
    else $error("comms fault indication wrong");
  a_coded_status_red: assert property (s_coded_held |-> status_led_red_o)
    else $error("status LED dark during a fault");
  a_brake_yellow: assert property (s_brake_held |-> code_led_yellow_o)
    else $error("code LED not yellow during braking");
  a_run_green: assert property (s_run_held |-> run_led_green_o)
    else $error("run LED not steady while running");
  a_supply_dark: assert property ((!internal_power_supply_ok_i)[*3] |-> !run_led_green_o)
    else $error("run LED lit without supply");
  a_mode_analog: assert property ((input_mode_i == 4'h0)[*3] |-> analog_mode_o)
    else $error("terminal four not analog in default mode");
  a_mode_digital: assert property ((input_mode_i == 4'h4)[*3] |-> !analog_mode_o)
    else $error("terminal four still analog in digital mode");
endmodule // dcio_control_monitor

bind dcio_control dcio_control_monitor #(.ADC_W(ADC_W), .TICK_DIV(TICK_DIV)) dcio_mon (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .input_mode_i(input_mode_i),
  .stop_mode_i(stop_mode_i), .mains_present_i(mains_present_i),
  .internal_power_supply_ok_i(internal_power_supply_ok_i), .comm_fault_i(comm_fault_i),
  .fault_code_i(fault_code_i), .output_freq_zero_i(output_freq_zero_i),
  .dc_brake_i(dc_brake_i), .forward_enable_o(forward_enable_o),
  .reverse_enable_o(reverse_enable_o), .analog_mode_o(analog_mode_o),
  .run_relay_o(run_relay_o), .run_led_green_o(run_led_green_o),
  .status_led_red_o(status_led_red_o), .code_led_red_o(code_led_red_o),
  .code_led_yellow_o(code_led_yellow_o));

// ### dcio_control_test.sv
`timescale 1ns/1ns
`include "dcio_defines.vh"
module dcio_control_test;
  reg         sys_clk_i, nrst_i, inv, stop, mains, psu, comm, fz, brake, loop3;
  reg  [3:0]  closed, mode, fault;
  reg  [1:0]  range;
  reg  [7:0]  scale;
  reg  [11:0] ain;
  reg  [16:0] tab [0:9];
  wire [3:0]  term;
  wire [11:0] aref;
  wire [1:0]  psel;
  wire        forward_enable, reverse_enable, ff1, up, dn, ext, amode, lflt, lff1, relay, green, stat, cred, cyel;
  integer     err_count, compares, i, hr, hc, sp;

  dcio_switches dcio_switches_inst (.closed_i(closed), .term_o(term));
  dcio_control #(.ADC_W(12), .TICK_DIV(4)) dcio_control_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .digital_input_one_i(term[0]),
    .digital_input_two_i(term[1]), .digital_input_three_i(term[2]),
    .digital_input_four_i(term[3]), .analog_reference_input_i(ain), .loop_below_3ma_i(loop3),
    .input_mode_i(mode), .analog_range_i(range), .analog_scale_i(scale),
    .analog_invert_i(inv), .stop_mode_i(stop), .mains_present_i(mains),
    .internal_power_supply_ok_i(psu), .comm_fault_i(comm), .fault_code_i(fault),
    .output_freq_zero_i(fz), .dc_brake_i(brake), .forward_enable_o(forward_enable),
    .reverse_enable_o(reverse_enable), .fixed_frequency_one_o(ff1), .preset_frequency_select_o(psel),
    .speed_up_o(up), .speed_down_o(dn), .external_fault_input_o(ext), .analog_mode_o(amode),
    .analog_reference_o(aref), .loop_open_fault_o(lflt), .loop_open_ff1_o(lff1),
    .run_relay_o(relay), .run_led_green_o(green), .status_led_red_o(stat),
    .code_led_red_o(cred), .code_led_yellow_o(cyel));

  always #20 sys_clk_i = ~sys_clk_i;

  task cyc(input integer n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task summarize;
    begin
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task check(input [35:0] got, input [35:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // counts lit cycles of run and code LEDs and cycles where status and code differ
  task watch(input integer n);
    begin
      hr = 0; hc = 0; sp = 0;
      repeat (n)
      begin
        hr = hr + (green === 1'b1);
        hc = hc + (cred === 1'b1);
        sp = sp + (stat !== cred);
        cyc(1);
      end
    end
  endtask

  // finds the start of a pulse train after the dark pause, then counts its pulses
  task pulses(input [3:0] code);
    integer n, low, rises;
    reg prev;
    begin
      n = 0; low = 0; rises = 0; prev = 1'b0;
      while (n < 600 && !(cred === 1'b1 && low >= 40))
      begin
        low = (cred === 1'b1) ? 0 : low + 1; n = n + 1; cyc(1);
      end
      low = 0;
      while (n < 1200 && low < 40)
      begin
        if (cred === 1'b1 && !prev) rises = rises + 1;
        prev = (cred === 1'b1);
        low = prev ? 0 : low + 1; n = n + 1; cyc(1);
      end
      if (n >= 1200)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0t pulse train never settled", $time);
        summarize;
      end
      check(rises, code);
    end
  endtask

  initial begin
    sys_clk_i = 0; nrst_i = 0; closed = 0; mode = 0; fault = 0; range = 0; scale = 8'h80;
    inv = 0; stop = 0; mains = 1; psu = 1; comm = 0; fz = 0; brake = 0; loop3 = 0;
    ain = 12'h400; err_count = 0; compares = 0;
    // {mode, closed contacts, {analog, fwd, rev, ff1, preset, up, down, ext}}
    tab[0] = {4'h0, 4'h2, 9'h140}; tab[1] = {4'h3, 4'h2, 9'h140};
    tab[2] = {4'h2, 4'he, 9'h058}; tab[3] = {4'h2, 4'h4, 9'h008};
    tab[4] = {4'h4, 4'he, 9'h026}; tab[5] = {4'h4, 4'h1, 9'h080};
    tab[6] = {4'h5, 4'he, 9'h007}; tab[7] = {4'h6, 4'he, 9'h046};
    tab[8] = {4'h7, 4'he, 9'h019}; tab[9] = {4'h7, 4'h2, 9'h008};
    cyc(8);
    check({relay, amode}, 2'h1);
    nrst_i = 1;
    cyc(10); watch(128); check(hr, 8);
    mains = 0; cyc(3); watch(64);
    check({hr[11:0], hc[11:0], sp[11:0]}, {12'h0, 12'd32, 12'h0});
    mains = 1;
    for (i = 0; i < 10; i = i + 1)
    begin
      mode = tab[i][16:13]; closed = tab[i][12:9]; cyc(5);
      check({amode, forward_enable, reverse_enable, ff1, psel, up, dn, ext}, tab[i][8:0]);
    end
    mode = 0; closed = 0; cyc(5);
    scale = 8'hff; cyc(3); check(aref, 12'h7f8);
    scale = 8'h80; inv = 1; cyc(3); check(aref, 12'hbff);
    inv = 0; cyc(3); check(aref, 12'h400);
    loop3 = 1; range = 2'h2; cyc(5); check({lflt, lff1}, 2'h2);
    range = 2'h3; cyc(3); check({lflt, lff1}, 2'h1);
    range = 2'h0; cyc(3); check({lflt, lff1}, 2'h0);
    loop3 = 0; closed = 4'h1; cyc(5); check(relay, 1);
    brake = 1; cyc(5); check(cyel, 1);
    brake = 0; comm = 1; cyc(5); check({stat, cred, green}, 3'h6);
    comm = 0; psu = 0; cyc(5); check(green, 0);
    psu = 1;
    fault = 4'h2; cyc(2); check(relay, 0);
    pulses(4'h2);
    fault = 4'h1; pulses(4'h1);
    fault = 4'hd; pulses(4'hd);
    fault = 4'he; cyc(4); check({stat, cred}, 2'h3);
    fault = 0; cyc(3); check(relay, 1);
    closed = 0; cyc(5); check(relay, 0);
    stop = 1; closed = 4'h1; cyc(5); closed = 0; cyc(12); check(relay, 1);
    fz = 1; cyc(3); check(relay, 0);
    stop = 0; fz = 0; cyc(2);
    summarize;
  end
endmodule // dcio_control_test
